//--- rtl/gpiop_pkg.sv
// Purpose: Shared constants and types of the general purpose I/O port
// Assumes: APB register access, 32-bit data, word index times four
// Notes: Printed offsets are register indices, byte address is index*4
package gpiop_pkg;

  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;

  // Register indices
  localparam logic [9:0] IDX_STATUS = 10'h003;
  localparam logic [9:0] IDX_PORT = 10'h005;
  localparam logic [9:0] IDX_OPTION = 10'h081;
  localparam logic [9:0] IDX_DIR = 10'h085;
  localparam logic [9:0] IDX_IRQ = 10'h010;
  localparam logic [9:0] IDX_CFG = 10'h011;
  localparam logic [9:0] IDX_BITOP = 10'h012;
  localparam logic [9:0] IDX_SERIAL = 10'h013;

  // Reset values
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [5:0] RST_DIR = 6'h3F;
  localparam logic [7:0] RST_IRQ = 8'h00;
  localparam logic [7:0] RST_LATCH = 8'hC0;
  localparam logic [5:0] RST_ANALOG = 6'h17;
  localparam logic RST_MASTER_CLEAR_INPUT = 1'b1;
  localparam logic RST_CLOCK_OUT_FUNCTION = 1'b0;

  // Masks
  localparam logic [7:0] STATUS_RO_MASK = 8'h18;
  localparam logic [5:0] CHANGE_MASK = 6'h0B;
  localparam logic [5:0] ANALOG_CAPABLE = 6'h17;

  // Field positions
  localparam int OPT_PULLUP_DIS = 7;
  localparam int IRQ_CHG_EN = 3;
  localparam int IRQ_CHG_FLAG = 0;
  localparam int BIT_MASTER_CLEAR_INPUT = 3;
  localparam int BIT_CLOCK_OUT_FUNCTION = 4;
  localparam int BIT_OSC1 = 5;
  localparam int EE_SDA = 6;
  localparam int EE_SCL = 7;
  localparam int CFG_ANALOG_LSB = 0;
  localparam int CFG_OSC_LSB = 6;
  localparam int CFG_MASTER_CLEAR_INPUT = 9;
  localparam int CFG_CLOCK_OUT_FUNCTION = 10;
  localparam int BITOP_VAL = 3;
  localparam int SER_START = 0;
  localparam int SER_STOP = 1;
  localparam int SER_IDLE = 2;

  typedef enum logic [2:0] {
    GPIOP_OSC_LP,
    GPIOP_OSC_XT,
    GPIOP_OSC_HS,
    GPIOP_OSC_INTERNAL_RC_OSC_MODE,
    GPIOP_OSC_EXTERNAL_RC_OSC_MODE
  } gpiop_osc_t;

  localparam gpiop_osc_t RST_OSC = GPIOP_OSC_INTERNAL_RC_OSC_MODE;

endpackage

//--- rtl/gpiop_pin_cell.sv
// Purpose: Output driver, enable and pull-up of one port pin
// Assumes: All inputs synchronous to pclk
// Notes: Outputs are registered
module gpiop_pin_cell (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic latch_bit,
  input wire logic dir_bit,
  input wire logic alt_bit,
  input wire logic pull_en,
  input wire logic ovr_en,
  input wire logic ovr_level,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_pullup
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else if (ovr_en) begin
      pin_out <= ovr_level;
      pin_oe <= 1'b1;
    end else begin
      pin_out <= latch_bit;
      pin_oe <= ~dir_bit & ~alt_bit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_pullup <= 1'b0;
    end else begin
      pin_pullup <= pull_en;
    end
  end

endmodule

//--- rtl/gpiop_serial_monitor.sv
// Purpose: Watch the internal serial lines for start, stop and idle
// Assumes: Line levels synchronous to pclk
// Notes: Pulses last one cycle
module gpiop_serial_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sda_in,
  input wire logic scl_in,
  output logic start_seen,
  output logic stop_seen,
  output logic bus_idle
);

  logic sda_prev;
  logic scl_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_prev <= 1'b1;
      scl_prev <= 1'b1;
    end else begin
      sda_prev <= sda_in;
      scl_prev <= scl_in;
    end
  end

  // Data edge while clock stays high marks a condition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
      bus_idle <= 1'b1;
    end else begin
      start_seen <= scl_prev & scl_in & sda_prev & ~sda_in;
      stop_seen <= scl_prev & scl_in & ~sda_prev & sda_in;
      bus_idle <= sda_in & scl_in;
    end
  end

endmodule

//--- rtl/gpiop_port.sv
// Purpose: Six-bit general purpose I/O port with APB register access
// Assumes: Pins synchronous to pclk, presetn acts as power-on reset
// Notes: One wait state on every APB access
module gpiop_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpiop_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe,
  output logic [5:0] pin_pullup,
  input wire logic clock_out_function_level,
  input wire logic ee_sda_in,
  input wire logic ee_scl_in,
  output logic ee_sda_pull_low,
  output logic ee_scl_pull_low,
  output logic change_irq
);

  logic [7:0] core_status_flags;
  logic [7:0] option_config;
  logic [5:0] port_direction;
  logic [7:0] port_latch;
  logic [7:0] irq_control_reg;
  logic [5:0] analog_mask;
  gpiop_pkg::gpiop_osc_t osc_mode;
  logic master_clear_input_enable;
  logic clock_out_function_enable;
  logic [2:0] serial_status;
  logic [5:0] pin_snapshot;

  logic [gpiop_pkg::IDX_W-1:0] word_idx;
  logic aligned;
  logic hit_status;
  logic hit_port;
  logic hit_option;
  logic hit_dir;
  logic hit_irq;
  logic hit_cfg;
  logic hit_bitop;
  logic hit_serial;
  logic mapped;
  logic access;
  logic done;
  logic wr_go;
  logic rd_go;

  logic rc_mode;
  logic clock_out_function_active;
  logic [5:0] alt_mask;
  logic [5:0] dir_view;
  logic [5:0] pull_on;
  logic [5:0] chg_mask;
  logic [7:0] port_read_value;
  logic [7:0] bitop_value;
  logic chg_event;
  logic [31:0] read_value;
  logic start_seen;
  logic stop_seen;
  logic bus_idle;

  // Address decode
  assign word_idx = paddr[gpiop_pkg::ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign hit_status = aligned & (word_idx == gpiop_pkg::IDX_STATUS);
  assign hit_port = aligned & (word_idx == gpiop_pkg::IDX_PORT);
  assign hit_option = aligned & (word_idx == gpiop_pkg::IDX_OPTION);
  assign hit_dir = aligned & (word_idx == gpiop_pkg::IDX_DIR);
  assign hit_irq = aligned & (word_idx == gpiop_pkg::IDX_IRQ);
  assign hit_cfg = aligned & (word_idx == gpiop_pkg::IDX_CFG);
  assign hit_bitop = aligned & (word_idx == gpiop_pkg::IDX_BITOP);
  assign hit_serial = aligned & (word_idx == gpiop_pkg::IDX_SERIAL);
  assign mapped = hit_status | hit_port | hit_option | hit_dir |
                  hit_irq | hit_cfg | hit_bitop | hit_serial;

  // Access phase, one wait state, then completion
  assign access = psel & penable & ~pready;
  assign done = psel & penable & pready;
  assign wr_go = done & pwrite & ~pslverr;
  assign rd_go = done & ~pwrite & ~pslverr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      pslverr <= access & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (access) begin
      prdata <= read_value;
    end
  end

  // Pin ownership by configuration
  assign rc_mode = (osc_mode == gpiop_pkg::GPIOP_OSC_INTERNAL_RC_OSC_MODE) |
                   (osc_mode == gpiop_pkg::GPIOP_OSC_EXTERNAL_RC_OSC_MODE);
  assign clock_out_function_active = clock_out_function_enable & rc_mode;

  always_comb begin
    alt_mask = analog_mask & gpiop_pkg::ANALOG_CAPABLE;
    if (master_clear_input_enable) begin
      alt_mask[gpiop_pkg::BIT_MASTER_CLEAR_INPUT] = 1'b1;
    end
    if (clock_out_function_active) begin
      alt_mask[gpiop_pkg::BIT_CLOCK_OUT_FUNCTION] = 1'b1;
    end
    unique case (osc_mode)
      gpiop_pkg::GPIOP_OSC_INTERNAL_RC_OSC_MODE: begin
      end
      gpiop_pkg::GPIOP_OSC_EXTERNAL_RC_OSC_MODE: begin
        alt_mask[gpiop_pkg::BIT_OSC1] = 1'b1;
      end
      gpiop_pkg::GPIOP_OSC_LP,
      gpiop_pkg::GPIOP_OSC_XT,
      gpiop_pkg::GPIOP_OSC_HS: begin
        alt_mask[gpiop_pkg::BIT_OSC1] = 1'b1;
        alt_mask[gpiop_pkg::BIT_CLOCK_OUT_FUNCTION] = 1'b1;
      end
      default: begin
        alt_mask[gpiop_pkg::BIT_OSC1] = 1'b1;
        alt_mask[gpiop_pkg::BIT_CLOCK_OUT_FUNCTION] = 1'b1;
      end
    endcase
  end

  always_comb begin
    dir_view = port_direction;
    dir_view[gpiop_pkg::BIT_MASTER_CLEAR_INPUT] = 1'b1;
    if (!rc_mode) begin
      dir_view[5:4] = 2'b11;
    end
  end

  // Live pins, alternate functions read 0, serial lines as they stand
  assign port_read_value = {ee_scl_in, ee_sda_in,
                            pin_in & ~alt_mask};

  // Single bit change on the sampled pins, full byte to latches
  always_comb begin
    bitop_value = port_read_value;
    bitop_value[pwdata[2:0]] = pwdata[gpiop_pkg::BITOP_VAL];
  end

  always_comb begin
    pull_on = 6'h00;
    if (!option_config[gpiop_pkg::OPT_PULLUP_DIS]) begin
      pull_on = gpiop_pkg::CHANGE_MASK;
    end
    if (master_clear_input_enable) begin
      pull_on[gpiop_pkg::BIT_MASTER_CLEAR_INPUT] = 1'b1;
    end
  end

  always_comb begin
    chg_mask = gpiop_pkg::CHANGE_MASK;
    if (master_clear_input_enable) begin
      chg_mask[gpiop_pkg::BIT_MASTER_CLEAR_INPUT] = 1'b0;
    end
  end

  assign chg_event = irq_control_reg[gpiop_pkg::IRQ_CHG_EN] &
                     (|((port_read_value[5:0] ^ pin_snapshot) &
                        chg_mask));

  always_comb begin
    read_value = 32'h0000_0000;
    if (hit_status) begin
      read_value = {24'h00_0000, core_status_flags};
    end else if (hit_port) begin
      read_value = {24'h00_0000, port_read_value};
    end else if (hit_option) begin
      read_value = {24'h00_0000, option_config};
    end else if (hit_dir) begin
      read_value = {24'h00_0000, 2'b00, dir_view};
    end else if (hit_irq) begin
      read_value = {24'h00_0000, irq_control_reg};
    end else if (hit_cfg) begin
      read_value = {21'h00_0000, clock_out_function_enable, master_clear_input_enable,
                    osc_mode, analog_mask};
    end else if (hit_serial) begin
      read_value = {29'h0000_0000, serial_status};
    end
  end

  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_status_flags <= gpiop_pkg::RST_STATUS;
    end else if (wr_go & hit_status) begin
      core_status_flags <= (pwdata[7:0] & ~gpiop_pkg::STATUS_RO_MASK) |
                           (core_status_flags &
                            gpiop_pkg::STATUS_RO_MASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_config <= gpiop_pkg::RST_OPTION;
    end else if (wr_go & hit_option) begin
      option_config <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_direction <= gpiop_pkg::RST_DIR;
    end else if (wr_go & hit_dir) begin
      port_direction[2:0] <= pwdata[2:0];
      if (rc_mode) begin
        port_direction[5:4] <= pwdata[5:4];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_latch <= gpiop_pkg::RST_LATCH;
    end else if (wr_go & hit_port) begin
      port_latch <= pwdata[7:0];
    end else if (wr_go & hit_bitop) begin
      port_latch <= bitop_value;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_control_reg <= gpiop_pkg::RST_IRQ;
    end else begin
      if (wr_go & hit_irq) begin
        irq_control_reg <= pwdata[7:0];
      end
      if (chg_event) begin
        irq_control_reg[gpiop_pkg::IRQ_CHG_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_mask <= gpiop_pkg::RST_ANALOG;
      osc_mode <= gpiop_pkg::RST_OSC;
      master_clear_input_enable <= gpiop_pkg::RST_MASTER_CLEAR_INPUT;
      clock_out_function_enable <= gpiop_pkg::RST_CLOCK_OUT_FUNCTION;
    end else if (wr_go & hit_cfg) begin
      analog_mask <= pwdata[5:0];
      osc_mode <= gpiop_pkg::gpiop_osc_t'(pwdata[8:6]);
      master_clear_input_enable <= pwdata[gpiop_pkg::CFG_MASTER_CLEAR_INPUT];
      clock_out_function_enable <= pwdata[gpiop_pkg::CFG_CLOCK_OUT_FUNCTION];
    end
  end

  // Levels at the last port or bit-operation read or write, reference for change detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_snapshot <= 6'h00;
    end else if ((rd_go | wr_go) & (hit_port | hit_bitop)) begin
      pin_snapshot <= port_read_value[5:0];
    end
  end

  // Start and stop conditions, write 1 to clear, set wins; idle bit follows the lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_status <= 3'h0;
    end else begin
      if (wr_go & hit_serial) begin
        serial_status[1:0] <= serial_status[1:0] & ~pwdata[1:0];
      end
      if (start_seen) begin
        serial_status[gpiop_pkg::SER_START] <= 1'b1;
      end
      if (stop_seen) begin
        serial_status[gpiop_pkg::SER_STOP] <= 1'b1;
      end
      serial_status[gpiop_pkg::SER_IDLE] <= bus_idle;
    end
  end

  gpiop_serial_monitor u_serial_monitor (
    .pclk(pclk),
    .presetn(presetn),
    .sda_in(ee_sda_in),
    .scl_in(ee_scl_in),
    .start_seen(start_seen),
    .stop_seen(stop_seen),
    .bus_idle(bus_idle)
  );

  // Serial lines are open drain and stay inside the device
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_sda_pull_low <= 1'b0;
      ee_scl_pull_low <= 1'b0;
    end else begin
      ee_sda_pull_low <= ~port_latch[gpiop_pkg::EE_SDA];
      ee_scl_pull_low <= ~port_latch[gpiop_pkg::EE_SCL];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      change_irq <= 1'b0;
    end else begin
      change_irq <= irq_control_reg[gpiop_pkg::IRQ_CHG_FLAG] &
                    irq_control_reg[gpiop_pkg::IRQ_CHG_EN];
    end
  end

  // Pin drivers
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_pin
      gpiop_pin_cell u_cell (
        .pclk(pclk),
        .presetn(presetn),
        .latch_bit(port_latch[gi]),
        .dir_bit(dir_view[gi]),
        .alt_bit(alt_mask[gi]),
        .pull_en(pull_on[gi]),
        .ovr_en(clock_out_function_active && (gi == gpiop_pkg::BIT_CLOCK_OUT_FUNCTION)),
        .ovr_level(clock_out_function_level),
        .pin_out(pin_out[gi]),
        .pin_oe(pin_oe[gi]),
        .pin_pullup(pin_pullup[gi])
      );
    end
  endgenerate

endmodule

//--- sim/gpiop_props.sv
// Purpose: Port-level assertions of the I/O port
// Assumes: One clock domain, presetn async low
// Notes: Bound to gpiop_port from the testbench
module gpiop_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] pin_pullup
);
  logic mapped;
  assign mapped = paddr inside {12'h00C, 12'h014, 12'h204, 12'h214,
    12'h040, 12'h044, 12'h048, 12'h04C};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_next;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("no pready after access cycle");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  property p_ready_access;
    pready |-> psel && penable;
  endproperty
  a_ready_access: assert property (p_ready_access)
    else $error("pready outside access phase");
  property p_err_decode;
    pready |-> pslverr == !mapped;
  endproperty
  a_err_decode: assert property (p_err_decode)
    else $error("pslverr does not match decode");
  property p_err_zero;
    pready && pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("refused read returned data");
  property p_rdata_width;
    pready && !pwrite && paddr != 12'h044 |-> prdata[31:8] == 24'h0;
  endproperty
  a_rdata_width: assert property (p_rdata_width)
    else $error("read data above bit seven");
  property p_bit3_input;
    pready |-> ##1 !pin_oe[3] [*3];
  endproperty
  a_bit3_input: assert property (p_bit3_input)
    else $error("input only pin driven");
  property p_pullup_bits;
    (pin_pullup & 6'h34) == 6'h0 && pin_pullup[0] == pin_pullup[1];
  endproperty
  a_pullup_bits: assert property (p_pullup_bits)
    else $error("pull-up on wrong pin");
  property p_latch_hold;
    !(pready && pwrite) |-> ##2 $stable({pin_out[3:0], pin_oe[3:0]});
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("pin output changed without write");
endmodule

//--- sim/gpiop_board.sv
// Purpose: Board circuitry and serial line pull-ups around the port
// Assumes: Bench decides which pins are held externally
// Notes: Undriven pins without pull-up toggle every cycle
module gpiop_board (
  input wire logic pclk,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] pin_pullup,
  input wire logic [5:0] ext_drive,
  input wire logic [5:0] ext_level,
  input wire logic sda_pull_low,
  input wire logic scl_pull_low,
  output logic [5:0] pin_in,
  output logic sda_line,
  output logic scl_line
);
  logic [5:0] float_pat = 6'h2A;
  always_ff @(posedge pclk) begin
    float_pat <= ~float_pat;
  end
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (ext_drive[i])
        pin_in[i] = ext_level[i];
      else if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (pin_pullup[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = float_pat[i];
    end
  end
  // Open-drain lines with pull-up, memory never pulls
  assign sda_line = !sda_pull_low;
  assign scl_line = !scl_pull_low;
endmodule

//--- sim/testbench.sv
// Purpose: Self-checking bench of the I/O port
// Assumes: APB master tasks, board model on the pins
// Notes: Expected values follow the register map
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("wrong value at %0t: %h not %h", $time, got, exp); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] A_STAT = 12'h00C;
  localparam logic [11:0] A_PORT = 12'h014;
  localparam logic [11:0] A_OPT = 12'h204;
  localparam logic [11:0] A_DIR = 12'h214;
  localparam logic [11:0] A_IRQ = 12'h040;
  localparam logic [11:0] A_CFG = 12'h044;
  localparam logic [11:0] A_BIT = 12'h048;
  localparam logic [11:0] A_SER = 12'h04C;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] pin_in;
  logic [5:0] pin_out;
  logic [5:0] pin_oe;
  logic [5:0] pin_pullup;
  logic clock_out_function_level = 1'b0;
  logic ee_sda_in;
  logic ee_scl_in;
  logic ee_sda_pull_low;
  logic ee_scl_pull_low;
  logic change_irq;
  logic [5:0] ext_drive = 6'h0;
  logic [5:0] ext_level = 6'h0;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int checks_done = 0;
  always #10 pclk = ~pclk;
  gpiop_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .clock_out_function_level(clock_out_function_level),
    .ee_sda_in(ee_sda_in), .ee_scl_in(ee_scl_in),
    .ee_sda_pull_low(ee_sda_pull_low), .ee_scl_pull_low(ee_scl_pull_low),
    .change_irq(change_irq));
  gpiop_board board (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_drive(ext_drive),
    .ext_level(ext_level), .sda_pull_low(ee_sda_pull_low),
    .scl_pull_low(ee_scl_pull_low), .pin_in(pin_in),
    .sda_line(ee_sda_in), .scl_line(ee_scl_in));
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd[7:0], e)
  endtask
  task automatic drive(input logic [5:0] d, input logic [5:0] l);
    @(posedge pclk);
    ext_drive <= d;
    ext_level <= l;
  endtask
  task automatic settle;
    @(posedge pclk);
    @(negedge pclk);
  endtask
  initial begin
    #100000;
    fail_count++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    drive(6'h20, 6'h20);
    settle;
    `CHK(pin_oe, 6'h00)
    `CHK(pin_pullup, 6'h08)
    rdchk(A_OPT, 8'hFF);
    rdchk(A_DIR, 8'h3F);
    rdchk(A_STAT, 8'h18);
    rdchk(A_PORT, 8'hE0);
    rdchk(12'h100, 8'h00);
    `CHK(err, 1'b1)
    wr(A_DIR, 32'h00);
    rdchk(A_DIR, 8'h08);
    settle;
    `CHK(pin_oe, 6'h20)
    wr(A_CFG, 32'h0C0);
    wr(A_PORT, 32'hD5);
    drive(6'h08, 6'h08);
    settle;
    `CHK(pin_oe, 6'h37)
    `CHK(pin_out & 6'h37, 6'h15)
    rdchk(A_PORT, 8'hDD);
    drive(6'h09, 6'h08);
    rdchk(A_PORT, 8'hDC);
    wr(A_BIT, 32'h0D);
    drive(6'h08, 6'h08);
    settle;
    `CHK(pin_out & 6'h37, 6'h34)
    wr(A_CFG, 32'h040);
    rdchk(A_DIR, 8'h38);
    rdchk(A_PORT, 8'hCC);
    settle;
    `CHK(pin_oe, 6'h07)
    wr(A_CFG, 32'h4C0);
    wr(A_DIR, 32'h10);
    settle;
    `CHK(pin_oe[4], 1'b1)
    `CHK(pin_out[4], 1'b0)
    @(posedge pclk);
    clock_out_function_level <= 1'b1;
    settle;
    `CHK(pin_out[4], 1'b1)
    @(posedge pclk);
    clock_out_function_level <= 1'b0;
    rdchk(A_PORT, 8'hEC);
    wr(A_OPT, 32'h7F);
    wr(A_CFG, 32'h0C0);
    settle;
    `CHK(pin_pullup, 6'h0B)
    wr(A_DIR, 32'h3F);
    drive(6'h3F, 6'h08);
    rdchk(A_PORT, 8'hC8);
    wr(A_IRQ, 32'h08);
    drive(6'h3F, 6'h0A);
    settle;
    settle;
    `CHK(change_irq, 1'b1)
    rdchk(A_IRQ, 8'h09);
    rdchk(A_PORT, 8'hCA);
    wr(A_IRQ, 32'h08);
    rdchk(A_IRQ, 8'h08);
    wr(A_IRQ, 32'h00);
    drive(6'h3F, 6'h08);
    settle;
    rdchk(A_IRQ, 8'h00);
    rdchk(A_PORT, 8'hC8);
    wr(A_IRQ, 32'h08);
    drive(6'h3F, 6'h0C);
    settle;
    rdchk(A_IRQ, 8'h08);
    `CHK(change_irq, 1'b0)
    wr(A_PORT, 32'hBC);
    settle;
    `CHK(ee_sda_pull_low, 1'b1)
    rdchk(A_SER, 8'h01);
    wr(A_PORT, 32'hFC);
    settle;
    rdchk(A_SER, 8'h07);
    wr(A_PORT, 32'h7C);
    settle;
    `CHK(ee_scl_pull_low, 1'b1)
    complete_run;
  end
endmodule
bind gpiop_port gpiop_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
